// File: hw/upf_usart.sv
`timescale 1ns/1ps
`default_nettype none
module upf_usart (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        link_clk,
   output logic             txd,
   input  wire logic        rxd,
   output logic             rts_n,
   input  wire logic        cts_n,
   input  wire logic        io_in,
   output logic             io_out,
   output logic             io_oe,
   output logic             irq
);
   logic [12:0]         ctrl_a_q;
   logic [2:0]          ctrl_b_q;
   logic [10:0]         ctrl_c_q;
   logic [upf_pkg::ST_W-1:0] status_q;
   logic [upf_pkg::ST_W-1:0] mask_q;
   logic [7:0]          tally_q;
   logic [7:0]          tx_hold_q;
   logic                tx_pend_q;
   logic [7:0]          rx_data_q;
   logic                rx_valid_q;
   logic [3:0]          sync_v;
   logic                lclk_prev_q;
   logic                rise_tick;
   logic                fall_tick;
   upf_pkg::upf_tx_state_t tx_state_q;
   upf_pkg::upf_rx_state_t rx_state_q;
   logic [7:0]          tx_char_q;
   logic [7:0]          tx_sh_q;
   logic                tx_par_q;
   logic [3:0]          tx_cnt_q;
   logic [2:0]          resend_q;
   logic                tx_nack_q;
   logic                tx_load;
   logic                tx_done;
   logic                tx_nack_ev;
   logic [7:0]          rx_sh_q;
   logic [3:0]          rx_cnt_q;
   logic                rx_nacked_q;
   logic [2:0]          nack_run_q;
   logic                nack_pend_q;
   logic                nack_drive_q;
   logic                rx_store;
   logic                rx_parity_error_flag;
   logic                rx_line;
   logic                par_on;
   logic                t0_on;
   logic                flow_ok;
   logic                odd_sel;
   logic [3:0]          guard_last;
   logic                wr_ctrl_a, wr_ctrl_b, wr_ctrl_c, wr_data, wr_status, wr_mask;
   logic                rd_data, rd_tally;
   logic                line_bit;
   logic                nack_allowed;
   logic [upf_pkg::ST_W-1:0] st_set;

   upf_sync #(.W(4)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({link_clk, rxd, cts_n, io_in}),
      .sync_out (sync_v)
   );

   // Mode decode
   assign odd_sel = ctrl_b_q[upf_pkg::B_ODD_BIT];
   assign par_on  = (ctrl_a_q[upf_pkg::A_FRAME_LSB +: 4] == upf_pkg::FRAME_PARITY) || t0_on;
   assign t0_on   = ctrl_a_q[upf_pkg::A_T0_BIT] & ctrl_a_q[upf_pkg::A_SYNC_BIT];
   assign flow_ok = (ctrl_a_q[upf_pkg::A_OPMODE_LSB +: 3] == upf_pkg::OPMODE_INT_CLK)
                    && !ctrl_a_q[upf_pkg::A_SYNC_BIT]
                    && (ctrl_a_q[upf_pkg::A_PAD_LSB +: 2] == upf_pkg::PAD_FLOW);
   assign guard_last = upf_pkg::T0_GUARD_BITS - 4'h1 + {1'b0, ctrl_c_q[upf_pkg::C_GUARD_LSB +: 3]};

   // Bit timing from the sampled link clock: rise starts a bit, fall samples it
   assign rise_tick = sync_v[3] & ~lclk_prev_q;
   assign fall_tick = ~sync_v[3] & lclk_prev_q;
   always_ff @(posedge clk) begin
      if (sys_rst) lclk_prev_q <= 1'b1;
      else         lclk_prev_q <= sync_v[3];
   end

   // Register decode
   assign wr_ctrl_a = reg_wr && reg_addr == upf_pkg::OFF_CTRL_A;
   assign wr_ctrl_b = reg_wr && reg_addr == upf_pkg::OFF_CTRL_B;
   assign wr_ctrl_c = reg_wr && reg_addr == upf_pkg::OFF_CTRL_C;
   assign wr_data   = reg_wr && reg_addr == upf_pkg::OFF_DATA;
   assign wr_status = reg_wr && reg_addr == upf_pkg::OFF_STATUS;
   assign wr_mask   = reg_wr && reg_addr == upf_pkg::OFF_MASK;
   assign rd_data   = reg_rd && reg_addr == upf_pkg::OFF_DATA;
   assign rd_tally  = reg_rd && reg_addr == upf_pkg::OFF_TALLY;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_a_q <= upf_pkg::CTRL_A_RST;
         ctrl_b_q <= upf_pkg::CTRL_B_RST;
         ctrl_c_q <= upf_pkg::CTRL_C_RST;
         mask_q   <= upf_pkg::MASK_RST;
      end else begin
         if (wr_ctrl_a) ctrl_a_q <= reg_wdata[12:0];
         if (wr_ctrl_b) ctrl_b_q <= reg_wdata[2:0];
         if (wr_ctrl_c) ctrl_c_q <= reg_wdata[10:0];
         if (wr_mask)   mask_q   <= reg_wdata[upf_pkg::ST_W-1:0];
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            unique case (reg_addr)
               upf_pkg::OFF_CTRL_A: reg_rdata <= {19'h0_0000, ctrl_a_q};
               upf_pkg::OFF_CTRL_B: reg_rdata <= {29'h0000_0000, ctrl_b_q};
               upf_pkg::OFF_CTRL_C: reg_rdata <= {21'h00_0000, ctrl_c_q};
               upf_pkg::OFF_DATA:   reg_rdata <= {24'h00_0000, rx_data_q};
               upf_pkg::OFF_STATUS: reg_rdata <= {28'h000_0000, status_q};
               upf_pkg::OFF_MASK:   reg_rdata <= {28'h000_0000, mask_q};
               upf_pkg::OFF_TALLY:  reg_rdata <= {24'h00_0000, tally_q};
               default:             reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   assign st_set = {tx_nack_ev, tx_done, rx_store, rx_parity_error_flag};
   always_ff @(posedge clk) begin
      if (sys_rst) status_q <= '0;
      else status_q <= (status_q & ~(wr_status ? reg_wdata[upf_pkg::ST_W-1:0] : '0)) | st_set;
   end
   assign irq = |(status_q & mask_q);

   // Error tally: saturates, cleared by read; a coincident error still counts
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tally_q <= 8'h00;
      end else if (rx_parity_error_flag || tx_nack_ev) begin
         if (rd_tally) tally_q <= 8'h01;
         else if (tally_q != upf_pkg::TALLY_MAX) tally_q <= tally_q + 8'h01;
      end else if (rd_tally) begin
         tally_q <= 8'h00;
      end
   end

   // Transmit holding register: one character waiting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_hold_q <= 8'h00;
         tx_pend_q <= 1'b0;
      end else if (wr_data) begin
         tx_hold_q <= reg_wdata[7:0];
         tx_pend_q <= 1'b1;
      end else if (tx_load) begin
         tx_pend_q <= 1'b0;
      end
   end

   // Receive data register; reading it frees the receiver for flow control
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_data_q  <= 8'h00;
         rx_valid_q <= 1'b0;
      end else if (rx_store) begin
         rx_data_q  <= rx_sh_q;
         rx_valid_q <= 1'b1;
      end else if (rd_data) begin
         rx_valid_q <= 1'b0;
      end
   end

   // Start a new frame only while CTS is low under flow control
   assign tx_load = rise_tick && tx_state_q == upf_pkg::TX_IDLE && tx_pend_q
                    && ctrl_b_q[upf_pkg::B_TXEN_BIT] && !(flow_ok && sync_v[1]);
   assign tx_done = rise_tick && ((tx_state_q == upf_pkg::TX_STOP)
                    || (tx_state_q == upf_pkg::TX_GUARD && tx_cnt_q == guard_last + {3'h0, tx_nack_q}
                        && !(tx_nack_q && resend_q < ctrl_c_q[upf_pkg::C_ITER_LSB +: 3])));
   // Remote NACK: line low at the sample point of the first guard bit
   assign tx_nack_ev = fall_tick && tx_state_q == upf_pkg::TX_GUARD && tx_cnt_q == 4'h0
                       && !sync_v[0] && !tx_nack_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_state_q <= upf_pkg::TX_IDLE;
         tx_char_q  <= 8'h00;
         tx_sh_q    <= 8'h00;
         tx_par_q   <= 1'b0;
         tx_cnt_q   <= 4'h0;
         resend_q   <= 3'h0;
         tx_nack_q  <= 1'b0;
      end else begin
         if (tx_nack_ev) tx_nack_q <= 1'b1;
         if (rise_tick) begin
            unique case (tx_state_q)
               upf_pkg::TX_IDLE: begin
                  if (tx_load) begin
                     tx_char_q  <= tx_hold_q;
                     tx_sh_q    <= tx_hold_q;
                     tx_par_q   <= ^tx_hold_q ^ odd_sel;
                     resend_q   <= 3'h0;
                     tx_nack_q  <= 1'b0;
                     tx_state_q <= upf_pkg::TX_START;
                  end
               end
               upf_pkg::TX_START: begin
                  tx_cnt_q   <= 4'h0;
                  tx_state_q <= upf_pkg::TX_DATA;
               end
               upf_pkg::TX_DATA: begin
                  if (tx_cnt_q == upf_pkg::LAST_DATA_BIT) begin
                     tx_state_q <= par_on ? upf_pkg::TX_PAR : upf_pkg::TX_STOP;
                  end else begin
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                     tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  end
               end
               upf_pkg::TX_PAR: begin
                  tx_cnt_q   <= 4'h0;
                  tx_state_q <= t0_on ? upf_pkg::TX_GUARD : upf_pkg::TX_STOP;
               end
               upf_pkg::TX_STOP: tx_state_q <= upf_pkg::TX_IDLE;
               upf_pkg::TX_GUARD: begin
                  // NACK adds one bit time before the guard ends
                  if (tx_cnt_q == guard_last + {3'h0, tx_nack_q}) begin
                     if (tx_nack_q && resend_q < ctrl_c_q[upf_pkg::C_ITER_LSB +: 3]) begin
                        resend_q   <= resend_q + 3'h1;
                        tx_sh_q    <= tx_char_q;
                        tx_nack_q  <= 1'b0;
                        tx_state_q <= upf_pkg::TX_START;
                     end else begin
                        tx_state_q <= upf_pkg::TX_IDLE;
                     end
                  end else begin
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                  end
               end
               default: tx_state_q <= upf_pkg::TX_IDLE;
            endcase
         end
      end
   end

   // Receiver, sampling mid-bit; in T=0 it ignores its own transmission
   assign rx_line = t0_on ? sync_v[0] : sync_v[2];
   assign nack_allowed = !ctrl_c_q[upf_pkg::C_INHIB_BIT]
                         && !(ctrl_c_q[upf_pkg::C_RUNLIM_BIT]
                              && nack_run_q >= ctrl_c_q[upf_pkg::C_ITER_LSB +: 3]);
   assign rx_parity_error_flag  = fall_tick && rx_state_q == upf_pkg::RX_PAR
                     && ((^rx_sh_q ^ odd_sel) != rx_line);
   assign rx_store = fall_tick && ((rx_state_q == upf_pkg::RX_STOP)
                     || (rx_state_q == upf_pkg::RX_PAR && t0_on && !(rx_parity_error_flag && nack_allowed)));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_state_q  <= upf_pkg::RX_IDLE;
         rx_sh_q     <= 8'h00;
         rx_cnt_q    <= 4'h0;
         rx_nacked_q <= 1'b0;
         nack_run_q  <= 3'h0;
         nack_pend_q <= 1'b0;
      end else if (fall_tick) begin
         unique case (rx_state_q)
            upf_pkg::RX_IDLE: begin
               if (ctrl_b_q[upf_pkg::B_RXEN_BIT] && !rx_line
                   && !(t0_on && tx_state_q != upf_pkg::TX_IDLE)) begin
                  rx_cnt_q   <= 4'h0;
                  rx_state_q <= upf_pkg::RX_DATA;
               end
            end
            upf_pkg::RX_DATA: begin
               rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
               rx_cnt_q <= rx_cnt_q + 4'h1;
               if (rx_cnt_q == upf_pkg::LAST_DATA_BIT) begin
                  rx_state_q <= par_on ? upf_pkg::RX_PAR : upf_pkg::RX_STOP;
               end
            end
            upf_pkg::RX_PAR: begin
               rx_cnt_q <= 4'h0;
               if (t0_on) begin
                  rx_nacked_q <= rx_parity_error_flag && nack_allowed;
                  nack_pend_q <= rx_parity_error_flag && nack_allowed;
                  if (rx_parity_error_flag && nack_allowed) nack_run_q <= nack_run_q + 3'h1;
                  else nack_run_q <= 3'h0;
                  rx_state_q <= upf_pkg::RX_GUARD;
               end else begin
                  rx_state_q <= upf_pkg::RX_STOP;
               end
            end
            upf_pkg::RX_STOP: rx_state_q <= upf_pkg::RX_IDLE;
            upf_pkg::RX_GUARD: begin
               // Wait out the guard so the NACK is not taken as a start bit
               if (rx_cnt_q == upf_pkg::T0_GUARD_BITS - 4'h1 + {3'h0, rx_nacked_q}) rx_state_q <= upf_pkg::RX_IDLE;
               else rx_cnt_q <= rx_cnt_q + 4'h1;
            end
            default: rx_state_q <= upf_pkg::RX_IDLE;
         endcase
      end else if (rise_tick) begin
         nack_pend_q <= 1'b0;
      end
   end

   // NACK lasts exactly one bit time, from the rise after parity
   always_ff @(posedge clk) begin
      if (sys_rst) nack_drive_q <= 1'b0;
      else if (rise_tick) nack_drive_q <= nack_pend_q;
   end

   // Pin stage: one clock behind the state, keeps outputs glitch free
   always_comb begin
      unique case (tx_state_q)
         upf_pkg::TX_START: line_bit = 1'b0;
         upf_pkg::TX_DATA:  line_bit = tx_sh_q[0];
         upf_pkg::TX_PAR:   line_bit = tx_par_q;
         default:           line_bit = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txd    <= 1'b1;
         io_out <= 1'b1;
         io_oe  <= 1'b0;
         rts_n  <= 1'b1;
      end else begin
         txd    <= t0_on ? 1'b1 : line_bit;
         io_out <= nack_drive_q ? 1'b0 : line_bit;
         // Released in guard time unless sending our own NACK
         io_oe  <= t0_on && (nack_drive_q || tx_state_q == upf_pkg::TX_START
                   || tx_state_q == upf_pkg::TX_DATA || tx_state_q == upf_pkg::TX_PAR);
         rts_n  <= flow_ok && rx_valid_q;
      end
   end

endmodule // upf_usart
`default_nettype wire

// File: hw/upf_pkg.sv
package upf_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_CTRL_C = 8'h08;
   localparam logic [7:0] OFF_DATA   = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK   = 8'h14;
   localparam logic [7:0] OFF_TALLY  = 8'h18;

   // control_word_a fields
   localparam int A_OPMODE_LSB = 0;
   localparam int A_SYNC_BIT   = 3;
   localparam int A_PAD_LSB    = 4;
   localparam int A_FRAME_LSB  = 8;
   localparam int A_T0_BIT     = 12;
   // control_word_b fields
   localparam int B_ODD_BIT    = 0;
   localparam int B_TXEN_BIT   = 1;
   localparam int B_RXEN_BIT   = 2;
   // control_word_c fields
   localparam int C_GUARD_LSB  = 0;
   localparam int C_INHIB_BIT  = 4;
   localparam int C_RUNLIM_BIT = 5;
   localparam int C_ITER_LSB   = 8;
   // Status and mask bits
   localparam int ST_PAR_ERR   = 0;
   localparam int ST_RXC       = 1;
   localparam int ST_TXC       = 2;
   localparam int ST_NACK      = 3;
   localparam int ST_W         = 4;

   // Reset values
   localparam logic [12:0]   CTRL_A_RST = 13'h0000;
   localparam logic [2:0]    CTRL_B_RST = 3'h0;
   localparam logic [10:0]   CTRL_C_RST = 11'h000;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;

   // Encodings and counts
   localparam logic [2:0] OPMODE_INT_CLK = 3'h1;
   localparam logic [1:0] PAD_FLOW       = 2'h2;
   localparam logic [3:0] FRAME_PARITY   = 4'h1;
   localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
   localparam logic [3:0] T0_GUARD_BITS  = 4'h2;
   localparam logic [7:0] TALLY_MAX      = 8'hFF;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} upf_tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP, RX_GUARD} upf_rx_state_t;

endpackage

// File: hw/upf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module upf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // upf_sync
`default_nettype wire

// File: test/upf_usart_properties.sv
`timescale 1ns/1ps
`default_nettype none
module upf_usart_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        txd,
   input wire logic        rts_n,
   input wire logic        io_out,
   input wire logic        io_oe,
   input wire logic        irq
);
   logic [6:0] low_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Cycles since the line was released; saturates so a long idle never wraps
   always_ff @(posedge clk) begin
      if (sys_rst) low_q <= 7'h7F;
      else if (io_oe) low_q <= 7'h00;
      else if (low_q != 7'h7F) low_q <= low_q + 7'h01;
   end

   property p_rst_idle;
      disable iff (1'b0) sys_rst |=> txd && io_out && !io_oe && rts_n && !irq && reg_rdata == 32'h0000_0000;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
   property p_unmapped;
      reg_rd && reg_addr == 8'h1C |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_oe_low;
      $rose(io_oe) |-> !io_out;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("line taken at high level");
   property p_oe_hold;
      $rose(io_oe) |=> io_oe [*8];
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("line drive shorter than a bit");
   property p_io_bit;
      io_oe && $changed(io_out) |=> $stable(io_out) [*8];
   endproperty
   a_io_bit: assert property (p_io_bit) else $error("io bit too short");
   property p_txd_bit;
      $changed(txd) |=> $stable(txd) [*8];
   endproperty
   a_txd_bit: assert property (p_txd_bit) else $error("txd bit too short");
   property p_t0_txd;
      io_oe |-> txd;
   endproperty
   a_t0_txd: assert property (p_t0_txd) else $error("txd active during line drive");
   property p_guard;
      $rose(io_oe) |-> low_q >= 7'h38;
   endproperty
   a_guard: assert property (p_guard) else $error("line retaken inside guard time");
endmodule // upf_usart_chk

bind upf_usart upf_usart_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .txd(txd), .rts_n(rts_n), .io_out(io_out), .io_oe(io_oe), .irq(irq));
`default_nettype wire

// File: test/upf_card.sv
`timescale 1ns/1ps
`default_nettype none
module upf_card (
   input  wire logic run,
   input  wire logic txd,
   input  wire logic io_out,
   input  wire logic io_oe,
   output logic      link_clk,
   output logic      rxd,
   output logic      io_in
);
   logic c_oe;
   logic c_out;

   // Open-drain line with pull-up: either party can only pull it low
   assign io_in = (io_oe ? io_out : 1'b1) & (c_oe ? c_out : 1'b1);

   // Odd offset keeps link edges apart from the system clock edges
   initial begin
      link_clk = 1'b0;
      rxd      = 1'b1;
      c_oe     = 1'b0;
      c_out    = 1'b1;
      #1.3;
      forever begin
         #80;
         link_clk = run & ~link_clk;
      end
   end

   task automatic send(input logic [7:0] d, input logic p, input logic t0, output logic nack);
      logic [9:0] f;
      f = {p, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge link_clk);
         c_oe  = t0;
         c_out = f[i];
         rxd   = t0 ? 1'b1 : f[i];
      end
      @(posedge link_clk);
      c_oe = 1'b0;
      rxd  = 1'b1;
      @(negedge link_clk);
      nack = ~io_in;
      repeat (3) @(posedge link_clk);
   endtask

   task automatic recv(input logic t0, input logic nak, output logic [8:0] d, output logic ok, output int n);
      d = 9'h000;
      for (n = 0; n < 40; n++) begin
         @(negedge link_clk);
         if ((t0 ? io_in : txd) === 1'b0) break;
      end
      ok = (n < 40);
      for (int i = 0; i < 9 && ok; i++) begin
         @(negedge link_clk);
         d[i] = t0 ? io_in : txd;
      end
      if (ok && nak) begin
         @(posedge link_clk);
         c_oe  = 1'b1;
         c_out = 1'b0;
         @(posedge link_clk);
         c_oe = 1'b0;
      end
   endtask
endmodule // upf_card
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [31:0] B1  = 32'h0000_0001;
   localparam logic [31:0] ENB = (B1 << upf_pkg::B_TXEN_BIT) | (B1 << upf_pkg::B_RXEN_BIT);
   localparam logic [31:0] FRM = 32'(upf_pkg::FRAME_PARITY) << upf_pkg::A_FRAME_LSB;
   localparam logic [31:0] T0A = FRM | (B1 << upf_pkg::A_T0_BIT) | (B1 << upf_pkg::A_SYNC_BIT);
   localparam logic [31:0] FLW = FRM | 32'(upf_pkg::OPMODE_INT_CLK) | (32'(upf_pkg::PAD_FLOW) << upf_pkg::A_PAD_LSB);
   localparam logic [31:0] PE  = B1 << upf_pkg::ST_PAR_ERR;
   localparam logic [31:0] RC  = B1 << upf_pkg::ST_RXC;
   localparam logic [31:0] FF  = 32'h0000_00FF;
   // Entries: frame format parity, odd select, data byte
   localparam logic [9:0]  TV [5] = '{10'h25A, 10'h35A, 10'h207, 10'h307, 10'h107};

   logic        clk, sys_rst, reg_wr, reg_rd, run, cts_n, ok, nk;
   logic        link_clk, txd, rxd, rts_n, io_in, io_out, io_oe, irq;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [8:0]  fr;
   int          idle, miscompares, check_count;

   upf_usart u_upf_usart (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk), .txd(txd), .rxd(rxd),
      .rts_n(rts_n), .cts_n(cts_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .irq(irq));
   upf_card u_card (.run(run), .txd(txd), .io_out(io_out), .io_oe(io_oe), .link_clk(link_clk), .rxd(rxd),
      .io_in(io_in));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, rv);
      chk(nm, e, rv & m);
   endtask

   task automatic print_verdict;
      if (miscompares == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #300000;
      miscompares++;
      print_verdict();
   end

   initial begin
      sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0000_0000; reg_wr = 1'b0; reg_rd = 1'b0;
      run = 1'b0; cts_n = 1'b1; miscompares = 0; check_count = 0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk("ctrl_a", upf_pkg::OFF_CTRL_A, '1, 32'(upf_pkg::CTRL_A_RST));
      rdchk("ctrl_b", upf_pkg::OFF_CTRL_B, '1, 32'(upf_pkg::CTRL_B_RST));
      rdchk("ctrl_c", upf_pkg::OFF_CTRL_C, '1, 32'(upf_pkg::CTRL_C_RST));
      rdchk("mask", upf_pkg::OFF_MASK, '1, 32'(upf_pkg::MASK_RST));
      rdchk("status", upf_pkg::OFF_STATUS, '1, 32'h0000_0000);
      rdchk("unmapped", 8'h1C, '1, 32'h0000_0000);
      run <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(upf_pkg::OFF_CTRL_A, TV[i][9] ? FRM : 32'h0000_0000);
         wr(upf_pkg::OFF_CTRL_B, ENB | 32'(TV[i][8]));
         wr(upf_pkg::OFF_DATA, 32'(TV[i][7:0]));
         u_card.recv(1'b0, 1'b0, fr, ok, idle);
         chk("tx_frame", {23'h1, TV[i][9] ? ^TV[i][7:0] ^ TV[i][8] : 1'b1, TV[i][7:0]}, {22'h0, ok, fr});
         repeat (80) @(posedge clk);
      end
      // Normal-mode parity error, then the interrupt path
      wr(upf_pkg::OFF_CTRL_A, FRM);
      wr(upf_pkg::OFF_CTRL_B, ENB);
      u_card.send(8'h33, 1'b1, 1'b0, nk);
      rdchk("parity_error_flag", upf_pkg::OFF_STATUS, PE, PE);
      rdchk("rx_data", upf_pkg::OFF_DATA, FF, 32'h0000_0033);
      @(negedge clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(upf_pkg::OFF_MASK, PE);
      @(negedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      wr(upf_pkg::OFF_STATUS, 32'h0000_000F);
      @(negedge clk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      // Flow control: held transmit, then receiver full
      wr(upf_pkg::OFF_CTRL_A, FLW);
      @(posedge clk) cts_n <= 1'b1;
      @(negedge clk);
      chk("rts_empty", 32'h0, {31'h0, rts_n});
      wr(upf_pkg::OFF_DATA, 32'h0000_00C3);
      u_card.recv(1'b0, 1'b0, fr, ok, idle);
      chk("cts_hold", 32'h0, {31'h0, ok});
      @(posedge clk) cts_n <= 1'b0;
      u_card.recv(1'b0, 1'b0, fr, ok, idle);
      chk("cts_go", 32'h0000_02C3, {22'h0, ok, fr});
      u_card.send(8'h5A, 1'b0, 1'b0, nk);
      @(negedge clk);
      chk("rts_full", 32'h1, {31'h0, rts_n});
      rdchk("flow_data", upf_pkg::OFF_DATA, FF, 32'h0000_005A);
      repeat (3) @(negedge clk);
      chk("rts_freed", 32'h0, {31'h0, rts_n});
      // T=0 transmit answered with NACK twice, one resend allowed
      rd(upf_pkg::OFF_TALLY, rv);
      wr(upf_pkg::OFF_CTRL_A, T0A);
      wr(upf_pkg::OFF_CTRL_C, (32'h3 << upf_pkg::C_GUARD_LSB) | (B1 << upf_pkg::C_ITER_LSB));
      wr(upf_pkg::OFF_STATUS, 32'h0000_000F);
      wr(upf_pkg::OFF_DATA, 32'h0000_0096);
      u_card.recv(1'b1, 1'b1, fr, ok, idle);
      chk("t0_tx", 32'h0000_0296, {22'h0, ok, fr});
      u_card.recv(1'b1, 1'b1, fr, ok, idle);
      chk("resend", 32'h0000_0296, {22'h0, ok, fr});
      chk("guard_len", 32'(upf_pkg::T0_GUARD_BITS) + 32'h3, 32'(idle));
      u_card.recv(1'b1, 1'b0, fr, ok, idle);
      chk("resend_stop", 32'h0, {31'h0, ok});
      rdchk("nack_flag", upf_pkg::OFF_STATUS, B1 << upf_pkg::ST_NACK, B1 << upf_pkg::ST_NACK);
      rdchk("tally_tx", upf_pkg::OFF_TALLY, FF, 32'h0000_0002);
      // T=0 receive: error, good character, inhibited error
      wr(upf_pkg::OFF_STATUS, 32'h0000_000F);
      u_card.send(8'h3C, 1'b1, 1'b1, nk);
      chk("nack_drv", 32'h1, {31'h0, nk});
      rdchk("parity_error_flag_t0", upf_pkg::OFF_STATUS, PE | RC, PE);
      rdchk("tally_rx", upf_pkg::OFF_TALLY, FF, 32'h0000_0001);
      rdchk("tally_clr", upf_pkg::OFF_TALLY, FF, 32'h0000_0000);
      u_card.send(8'h3C, 1'b0, 1'b1, nk);
      chk("ack", 32'h0, {31'h0, nk});
      rdchk("rx_good", upf_pkg::OFF_DATA, FF, 32'h0000_003C);
      wr(upf_pkg::OFF_CTRL_C, (B1 << upf_pkg::C_INHIB_BIT) | (B1 << upf_pkg::C_RUNLIM_BIT));
      wr(upf_pkg::OFF_STATUS, 32'h0000_000F);
      u_card.send(8'hA5, 1'b1, 1'b1, nk);
      chk("nack_inhibit", 32'h0, {31'h0, nk});
      rdchk("nack_inhibit_flag", upf_pkg::OFF_STATUS, PE | RC, PE | RC);
      rdchk("nack_inhibit_data", upf_pkg::OFF_DATA, FF, 32'h0000_00A5);
      run <= 1'b0;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
